// ===== include/trs_pkg.sv
// Summary of operation
// - calibration-finished flag clears when calibration starts, sets on finish
// - power-up lock failure flag sets when power-up sequence ends unlocked
// - main status bit 5 shows raw instantaneous lock, reading 1 after reset
// - main status bit 4 shows lock filtered by the lock criterion setting
// - main status bit 3 shows carrier when strength exceeds threshold
// - main status bits 2,1,0 mirror lock, data clock and data pins
// - eight active-high submodule reset completion flags in one register
// - signal strength is seven low bits; top bit reads 0
// - strength counts 1.5 dB each, relative to amplifier gain setting
// - average offset is 8-bit two's complement decision level
// - average offset equals baud rate times value divided by 16
// - instant offset is signed 8-bit, baud rate times value over 8
// - calibration converter value high nibble, pump current low nibble
// - 3-bit silicon revision in top bits, codes 2 to 7 reserved
// - applied 5-bit oscillator array setting in low bits of revision word
// - bit 6 is 1 when reference current exceeds oscillator core current
// - frequency comparator in bit 7, 6-bit calibration current in bits 5:0
// - mixer sample bits 7:6, in-phase 5:3, quadrature 2:0
// - upper eight bits of channel filter in-phase output, full width
package trs_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned ADDR_W_MIN  = 9;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PLL_PIN_STATUS  = 8'h40;
    localparam logic [7:0] IDX_RESET_COMPLETE  = 8'h41;
    localparam logic [7:0] IDX_SIGNAL_STRENGTH = 8'h42;
    localparam logic [7:0] IDX_AVG_FREQ_OFFSET = 8'h43;
    localparam logic [7:0] IDX_INST_FREQ_OFFSET = 8'h44;
    localparam logic [7:0] IDX_CAL_PUMP        = 8'h45;
    localparam logic [7:0] IDX_REV_ARRAY       = 8'h46;
    localparam logic [7:0] IDX_OSC_CAL         = 8'h47;
    localparam logic [7:0] IDX_CONV_SAMPLE     = 8'h48;
    localparam logic [7:0] IDX_FILT_INPHASE    = 8'h49;

    // ------------------------------------------------------------------
    // main status field positions
    // ------------------------------------------------------------------
    localparam int unsigned ST_CAL_DONE  = 7;
    localparam int unsigned ST_SEQ_FAIL  = 6;
    localparam int unsigned ST_LOCK_INST = 5;
    localparam int unsigned ST_LOCK_FILT = 4;
    localparam int unsigned ST_CARRIER   = 3;
    localparam int unsigned ST_LOCK_PIN  = 2;
    localparam int unsigned ST_CLK_PIN   = 1;
    localparam int unsigned ST_DATA_PIN  = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic RST_CAL_DONE  = 1'b0;
    localparam logic RST_SEQ_FAIL  = 1'b0;
    localparam logic RST_LOCK_INST = 1'b1;
    localparam logic RST_LOCK_FILT = 1'b0;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------------
    // filtered lock: consecutive locked cycles per criterion code
    // ------------------------------------------------------------------
    localparam int unsigned LOCK_CNT_W = 8;
    localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_0 = 8'h10;
    localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_1 = 8'h20;
    localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_2 = 8'h40;
    localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_3 = 8'h80;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // live internal signals, same clock as the bus
    typedef struct packed {
        logic       cal_start;
        logic       cal_finish;
        logic       pu_seq_start;
        logic       pu_seq_end;
        logic       pu_seq_locked;
        logic       lock_raw;
        logic [1:0] lock_criterion;
        logic [7:0] reset_complete;
        logic [6:0] strength;
        logic [6:0] carrier_threshold;
        logic [7:0] avg_offset;
        logic [7:0] inst_offset;
        logic [3:0] cal_converter;
        logic [3:0] charge_pump_current_code;
        logic [4:0] oscillator_array_setting;
        logic       oscillator_current_comparator;
        logic       freq_comparator;
        logic [5:0] oscillator_calibration_current;
        logic [1:0] mixer_sample;
        logic [2:0] conv_inphase;
        logic [2:0] conv_quad;
        logic [7:0] filt_inphase;
    } trs_live_t;

    // pad levels, asynchronous to the bus clock
    typedef struct packed {
        logic lock_pin;
        logic data_clock_pin;
        logic data_pin;
    } trs_pins_t;

    // state of the bank, apart from the pad synchroniser flops
    typedef struct packed {
        logic                  cal_done;
        logic                  seq_fail;
        logic                  lock_inst;
        logic                  lock_filt;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic [DATA_W-1:0]     rdata;
        logic                  ready;
        logic                  slverr;
    } trs_bank_state_t;

endpackage

// ===== hdl/trs_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// two-flop synchroniser for a vector of pad levels
// ----------------------------------------------------------------------
module trs_sync #(
    parameter int unsigned W = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } trs_sync_state_t;

    trs_sync_state_t state_q;
    trs_sync_state_t state_d;

    // refuse an empty vector
    if (W < 1)
    begin : g_chk
        $error("trs_sync: width must be at least one");
    end

    // first stage feeds only the second
    always_comb
    begin
        state_d        = state_q;
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;

endmodule
`default_nettype wire

// ===== hdl/trs_status_bank.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// read-only transceiver status bank, apb slave
// ----------------------------------------------------------------------
module trs_status_bank #(
    parameter int unsigned ADDR_W       = trs_pkg::ADDR_W,
    parameter logic [2:0]  SILICON_REV  = 3'h6  // arbitrary neutral value
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [trs_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output var  logic [trs_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire trs_pkg::trs_live_t         live,
    input  wire trs_pkg::trs_pins_t         pins
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < trs_pkg::ADDR_W_MIN)
    begin : g_chk_addr
        $error("trs_status_bank: address too narrow for register map");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int unsigned IDX_W = ADDR_W - 2;

    trs_pkg::trs_bank_state_t state_q;
    trs_pkg::trs_bank_state_t state_d;
    trs_pkg::trs_pins_t       pins_s;
    logic [IDX_W-1:0]         reg_idx;
    logic                     setup;
    logic                     carrier;
    logic [7:0]               status_byte;
    logic [7:0]               read_byte;
    logic                     read_hit;
    logic [trs_pkg::LOCK_CNT_W-1:0] lock_thr;

    // write data and strobes are never used: every register is read-only
    logic unused_wr;
    assign unused_wr = ^{pwdata, pstrb};

    // ------------------------------------------------------------------
    // pad level synchronisers
    // ------------------------------------------------------------------
    trs_sync #(
        .W (3)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins),
        .sync_out (pins_s)
    );

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // setup phase of an apb transfer; answer is staged here
    assign setup   = psel && !penable;
    assign reg_idx = paddr[ADDR_W-1:2];

    // ------------------------------------------------------------------
    // lock criterion to required locked run length
    // ------------------------------------------------------------------
    always_comb
    begin
        case (live.lock_criterion)
            2'h0:    lock_thr = trs_pkg::LOCK_CNT_0;
            2'h1:    lock_thr = trs_pkg::LOCK_CNT_1;
            2'h2:    lock_thr = trs_pkg::LOCK_CNT_2;
            2'h3:    lock_thr = trs_pkg::LOCK_CNT_3;
            default: lock_thr = trs_pkg::LOCK_CNT_3;
        endcase
    end

    // ------------------------------------------------------------------
    // main status byte
    // ------------------------------------------------------------------
    // carrier sense on strictly greater strength
    assign carrier = live.strength > live.carrier_threshold;

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[trs_pkg::ST_CAL_DONE]  = state_q.cal_done;
        status_byte[trs_pkg::ST_SEQ_FAIL]  = state_q.seq_fail;
        status_byte[trs_pkg::ST_LOCK_INST] = state_q.lock_inst;
        status_byte[trs_pkg::ST_LOCK_FILT] = state_q.lock_filt;
        status_byte[trs_pkg::ST_CARRIER]   = carrier;
        status_byte[trs_pkg::ST_LOCK_PIN]  = pins_s.lock_pin;
        status_byte[trs_pkg::ST_CLK_PIN]   = pins_s.data_clock_pin;
        status_byte[trs_pkg::ST_DATA_PIN]  = pins_s.data_pin;
    end

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    // live values pass unchanged; scaling is left to software
    always_comb
    begin
        read_hit  = 1'b1;
        read_byte = 8'h00;
        if (reg_idx == IDX_W'(trs_pkg::IDX_PLL_PIN_STATUS))
        begin
            read_byte = status_byte;
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_RESET_COMPLETE))
        begin
            read_byte = live.reset_complete;
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_SIGNAL_STRENGTH))
        begin
            // 1.5 dB per count, relative to amplifier_gain_setting
            read_byte = {1'b0, live.strength};
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_AVG_FREQ_OFFSET))
        begin
            // decision level, offset = baud * value / 16
            read_byte = live.avg_offset;
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_INST_FREQ_OFFSET))
        begin
            // signed, offset = baud * value / 8
            read_byte = live.inst_offset;
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_CAL_PUMP))
        begin
            read_byte = {live.cal_converter,
                         live.charge_pump_current_code};
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_REV_ARRAY))
        begin
            read_byte = {SILICON_REV,
                         live.oscillator_array_setting};
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_OSC_CAL))
        begin
            read_byte = {live.freq_comparator,
                         live.oscillator_current_comparator,
                         live.oscillator_calibration_current};
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_CONV_SAMPLE))
        begin
            read_byte = {live.mixer_sample, live.conv_inphase,
                         live.conv_quad};
        end
        else if (reg_idx == IDX_W'(trs_pkg::IDX_FILT_INPHASE))
        begin
            read_byte = live.filt_inphase;
        end
        else
        begin
            read_hit = 1'b0;
        end
        // misaligned byte address is unmapped
        if (paddr[1:0] != 2'h0)
        begin
            read_hit  = 1'b0;
            read_byte = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;

        // calibration finished: finish wins over a same-cycle start
        if (live.cal_start)
        begin
            state_d.cal_done = 1'b0;
        end
        if (live.cal_finish)
        begin
            state_d.cal_done = 1'b1;
        end

        // power-up lock failure: new sequence clears, failure sets
        if (live.pu_seq_start)
        begin
            state_d.seq_fail = 1'b0;
        end
        if (live.pu_seq_end && !live.pu_seq_locked)
        begin
            state_d.seq_fail = 1'b1;
        end

        // raw lock follows the detector, no filtering
        state_d.lock_inst = live.lock_raw;

        // filtered lock needs a run of locked cycles
        if (!live.lock_raw)
        begin
            state_d.lock_cnt  = '0;
            state_d.lock_filt = 1'b0;
        end
        else if (state_q.lock_cnt >= lock_thr)
        begin
            state_d.lock_filt = 1'b1;
        end
        else
        begin
            state_d.lock_cnt = state_q.lock_cnt + 1'b1;
        end

        // apb answer: staged in setup, shown for the access cycle
        state_d.ready  = setup;
        state_d.slverr = 1'b0;
        state_d.rdata  = '0;
        if (setup)
        begin
            state_d.slverr = !read_hit;
            // writes to mapped registers complete and change nothing
            if (!pwrite)
            begin
                state_d.rdata = {24'h00_0000, read_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q.cal_done  <= trs_pkg::RST_CAL_DONE;
            state_q.seq_fail  <= trs_pkg::RST_SEQ_FAIL;
            state_q.lock_inst <= trs_pkg::RST_LOCK_INST;
            state_q.lock_filt <= trs_pkg::RST_LOCK_FILT;
            state_q.lock_cnt  <= '0;
            state_q.rdata     <= trs_pkg::RST_RDATA;
            state_q.ready     <= 1'b0;
            state_q.slverr    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------------
    assign prdata  = state_q.rdata;
    assign pready  = state_q.ready;
    assign pslverr = state_q.slverr;

endmodule
`default_nettype wire

// ===== tb/trs_status_bank_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// port checker for the status bank
// ----------------------------------------------------------------------
module trs_status_bank_props #(
    parameter int unsigned ADDR_W      = trs_pkg::ADDR_W,
    parameter logic [2:0]  SILICON_REV = 3'h6
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [trs_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [trs_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire trs_pkg::trs_live_t         live,
    input wire trs_pkg::trs_pins_t         pins
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [1:0] age_q;
    logic [1:0] age_d;
    // cycles since reset release, saturating
    always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) age_q <= 2'h0;
        else age_q <= age_d;

    // setup cycles, status read once history is valid
    wire logic setup = psel && !penable;
    wire logic rd_st = setup && !pwrite && paddr == 12'h100 && age_q == 2'h3;

    property p_ready;
        setup |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready not a single pulse after setup");
    property p_cal_set;
        rd_st && $past(live.cal_finish) |=> prdata[7];
    endproperty
    a_cal_set: assert property (p_cal_set)
        else $error("calibration flag not set");
    property p_cal_clr;
        rd_st && $past(live.cal_start) && !$past(live.cal_finish) |=> !prdata[7];
    endproperty
    a_cal_clr: assert property (p_cal_clr)
        else $error("calibration flag not cleared");
    property p_seq;
        rd_st && $past(live.pu_seq_end) && !$past(live.pu_seq_locked)
            |=> prdata[6];
    endproperty
    a_seq: assert property (p_seq)
        else $error("lock failure flag not set");
    property p_inst;
        rd_st |=> prdata[5] == $past(live.lock_raw, 2);
    endproperty
    a_inst: assert property (p_inst)
        else $error("instant lock bit wrong");
    property p_carrier;
        rd_st |=> prdata[3] ==
            ($past(live.strength) > $past(live.carrier_threshold));
    endproperty
    a_carrier: assert property (p_carrier)
        else $error("carrier bit wrong");
    property p_strength;
        setup && !pwrite && paddr == 12'h108
            |=> prdata == {25'h0, $past(live.strength)};
    endproperty
    a_strength: assert property (p_strength)
        else $error("strength word wrong");
    property p_rev;
        setup && !pwrite && paddr == 12'h118 |=> prdata ==
            {24'h0, SILICON_REV, $past(live.oscillator_array_setting)};
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision word wrong");
    property p_write;
        pready && pwrite |-> prdata == 32'h0;
    endproperty
    a_write: assert property (p_write)
        else $error("write returned data");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("error response malformed");

    c_status: cover property (rd_st);
    c_err: cover property (pslverr);
    c_write: cover property (pready && pwrite);
endmodule

bind trs_status_bank trs_status_bank_props #(
    .ADDR_W      (ADDR_W),
    .SILICON_REV (SILICON_REV)
) u_trs_status_bank_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .live(live), .pins(pins)
);
`default_nettype wire

// ===== tb/trs_status_bank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// self-checking bench for the status bank
// ----------------------------------------------------------------------
module trs_status_bank_tb_top;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic        err;
    } trs_row_t;

    localparam logic [2:0] REV = 3'h5; // arbitrary revision code
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h0;
    logic [31:0]        pwdata = 32'h0;
    logic [3:0]         pstrb = 4'hf;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    trs_pkg::trs_live_t live = '0;
    trs_pkg::trs_pins_t pins = '0;
    int                 fails = 0;
    int                 tests_run = 0;
    trs_row_t           rows [12];
    logic [4:0]         ev [7] = '{5'h09, 5'h11, 5'h19, 5'h03, 5'h02, 5'h05,
                                   5'h06};
    logic [1:0]         evx [7] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
    logic [31:0]        d;
    logic [31:0]        st;
    logic               e;

    always #2 pclk = ~pclk;

    trs_status_bank #(
        .ADDR_W      (12),
        .SILICON_REV (REV)
    ) u_trs_status_bank (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .live(live), .pins(pins)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // apb transfer; keep leaves psel up for a back-to-back setup
    task automatic xfer(input logic w, input logic [11:0] a, input logic keep,
                        output logic [31:0] rd, output logic er);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= 32'hffff_ffff;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (!keep)
        begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // one-cycle event pulses: cal start, cal end, seq start, seq end
    task automatic pulse(input logic [3:0] p, input logic locked);
        {live.cal_start, live.cal_finish} <= p[3:2];
        {live.pu_seq_start, live.pu_seq_end} <= p[1:0];
        live.pu_seq_locked <= locked;
        @(posedge pclk);
        {live.cal_start, live.cal_finish} <= 2'h0;
        {live.pu_seq_start, live.pu_seq_end} <= 2'h0;
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge pclk);
        fails++;
        conclude();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        live.reset_complete <= 8'ha5;
        live.strength <= 7'h55;
        live.carrier_threshold <= 7'h20;
        live.avg_offset <= 8'h9c;
        live.inst_offset <= 8'h7f;
        {live.cal_converter, live.charge_pump_current_code} <= 8'hc3;
        live.oscillator_array_setting <= 5'h15;
        {live.freq_comparator, live.oscillator_current_comparator} <= 2'h1;
        live.oscillator_calibration_current <= 6'h2a;
        {live.mixer_sample, live.conv_inphase, live.conv_quad} <= 8'hae;
        live.filt_inphase <= 8'hd3;
        rows = '{'{12'h104, 32'ha5, 1'b0}, '{12'h108, 32'h55, 1'b0},
                 '{12'h10c, 32'h9c, 1'b0}, '{12'h110, 32'h7f, 1'b0},
                 '{12'h114, 32'hc3, 1'b0},
                 '{12'h118, {24'h0, REV, 5'h15}, 1'b0},
                 '{12'h11c, 32'h6a, 1'b0}, '{12'h120, 32'hae, 1'b0},
                 '{12'h124, 32'hd3, 1'b0}, '{12'h128, 32'h0, 1'b1},
                 '{12'h101, 32'h0, 1'b1}, '{12'hffc, 32'h0, 1'b1}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h100, 1'b0, d, e);
        chk(d, 32'h28);
        // table of readouts, issued back to back
        for (int i = 0; i < 12; i++)
        begin
            xfer(1'b0, rows[i].addr, i != 11, d, e);
            chk(d, rows[i].data);
            chk(32'(e), 32'(rows[i].err));
        end
        // calibration and power-up sequencing events
        for (int i = 0; i < 7; i++)
        begin
            pulse(ev[i][4:1], ev[i][0]);
            xfer(1'b0, 12'h100, 1'b0, d, e);
            chk(32'(d[7:6]), 32'(evx[i]));
        end
        // filtered lock for every criterion code
        for (int c = 0; c < 4; c++)
        begin
            live.lock_raw <= 1'b0;
            live.lock_criterion <= c[1:0];
            repeat (2) @(posedge pclk);
            live.lock_raw <= 1'b1;
            repeat (16 << c) @(posedge pclk);
            // read at the edge that completes the run, then just after
            xfer(1'b0, 12'h100, 1'b1, d, e);
            chk(32'(d[5:4]), 32'h2);
            xfer(1'b0, 12'h100, 1'b0, d, e);
            chk(32'(d[5:4]), 32'h3);
        end
        live.lock_raw <= 1'b0;
        repeat (2) @(posedge pclk);
        xfer(1'b0, 12'h100, 1'b0, d, e);
        chk(32'(d[5:4]), 32'h0);
        // carrier at and just above the threshold
        for (int s = 0; s < 2; s++)
        begin
            live.strength <= 7'h20 + s[6:0];
            xfer(1'b0, 12'h100, 1'b0, d, e);
            chk(32'(d[3]), 32'(s[0]));
        end
        // pad levels through the synchroniser
        for (int p = 0; p < 8; p++)
        begin
            pins <= trs_pkg::trs_pins_t'(p[2:0]);
            repeat (3) @(posedge pclk);
            xfer(1'b0, 12'h100, 1'b0, d, e);
            chk(32'(d[2:0]), 32'(p[2:0]));
        end
        // writes to all ten registers and one unmapped address leave the bank untouched
        xfer(1'b0, 12'h100, 1'b0, st, e);
        for (int i = 0; i < 10; i++)
        begin
            xfer(1'b1, 12'h100 + 12'(4 * i), 1'b1, d, e);
            chk(d, 32'h0);
            chk(32'(e), 32'h0);
        end
        xfer(1'b1, 12'h128, 1'b0, d, e);
        chk(32'(e), 32'h1);
        xfer(1'b0, 12'h100, 1'b0, d, e);
        chk(d, st);
        // second reset in mid-run
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h100, 1'b0, d, e);
        chk(d, 32'h28);
        conclude();
    end
endmodule
`default_nettype wire
